// ---- shared/core_defs.vh ----
// Constants for the processor mode and decode core
`ifndef CORE_DEFS_VH
`define CORE_DEFS_VH
// ==================== Register byte offsets and group tags ====================
`define A_ACC_LO    8'h00
`define A_ACC_HI    8'h04
`define A_QUO_LO    8'h08
`define A_QUO_HI    8'h0C
`define A_EXP       8'h10
`define A_TIMER     8'h14
`define A_IC        8'h18
`define A_IND       8'h1C
`define A_DBR       8'h20
`define A_PBR       8'h24
`define A_CTL       8'h28
`define A_FAULT     8'h2C
`define A_ISSUE     8'h30
`define A_ISSUE_HI  8'h34
`define A_FETCH     8'h38
`define A_OPER      8'h3C
`define A_IDX_TAG   3'h2
`define A_ABR_TAG   3'h3
// ==================== Modes and fields ====================
`define MODE_ABS    2'h0
`define MODE_MAS    2'h1
`define MODE_SLV    2'h2
`define CTL_TSRC    4
`define IND_ZERO    0
`define IND_NEG     1
`define IND_CARRY   2
`define IND_OVF     3
`define IND_EOVF    4
`define IND_EUNF    5
`define IND_OMASK   6
`define IND_TALLY   7
`define IND_PAR     8
`define IND_PMASK   9
`define IND_ABS     10
`define F_PRIV      0
`define F_UNAS      1
`define F_TIMER     2
`define F_OVF       3
`define F_PAR       4
`define I_INH       28
`define I_BASE      29
// ==================== Opcodes ====================
`define OP_LIMIT    9'h194
`define OP_PRIV_TAG 5'h18
`define OP_LDX_TAG  6'h02
`define OP_LDA      9'h000
`define OP_LDQ      9'h001
`define OP_ADA      9'h002
`define OP_CMPA     9'h003
`define OP_LDE      9'h004
`define OP_FADE     9'h005
`define OP_LLS      9'h006
`define OP_LDBR     9'h180
`define OP_LDT      9'h181
`define OP_RPT      9'h190
// ==================== Timing ====================
`define CLK_NS      10
`define TICK_NS     15625
`define TICK_CYCLES (`TICK_NS / `CLK_NS)
`endif

// ---- rtl/processor_mode_and_decode_core.v ----
// Mode control, decode pipeline, timer and register file of the core
//
// Chosen here: the Wishbone register port and the address map.
`timescale 1ns/1ps
`include "core_defs.vh"
module processor_mode_and_decode_core #(
    parameter integer TICK_CYCLES = `TICK_CYCLES
) (
    input  wire        clk_i,
    input  wire        rst_i,
    input  wire [7:0]  adr_i,
    input  wire [31:0] dat_i,
    output reg  [31:0] dat_o,
    input  wire        we_i,
    input  wire [3:0]  sel_i,
    input  wire        cyc_i,
    input  wire        stb_i,
    output reg         ack_o,
    input  wire        mem_access_i,
    input  wire        parity_err_i,
    input  wire        intr_req_i,
    output reg         fault_o,
    output reg         intr_take_o,
    output reg  [23:0] fetch_addr_o,
    output reg  [23:0] oper_addr_o,
    output wire [1:0]  mode_o,
    output wire        busy_o
);
    localparam [11:0] TICK_LAST = TICK_CYCLES[11:0] - 12'h001;
    localparam [1:0]  RS_IDLE = 2'h0;
    localparam [1:0]  RS_CAPT = 2'h1;
    localparam [1:0]  RS_RUN  = 2'h2;

    // ====================
    // Architectural state
    reg [35:0] acc_reg;
    reg [35:0] quo_reg;
    reg [7:0]  exp_reg;
    reg [17:0] index_reg [0:7];
    reg [23:0] address_base [0:7];
    reg [23:0] timer_reg;
    reg [17:0] ic_reg;
    reg [17:0] ind_reg;
    reg [28:0] dbr_reg;
    reg [17:0] pbr_reg;
    reg [1:0]  mode_reg;
    reg        tsrc_reg;
    reg [4:0]  fault_reg;
    reg [3:0]  issue_hi_reg;
    reg [11:0] tick_reg;
    integer    k;

    // Pipeline: fetch, address prep, protection, execute
    reg        s1_v, s2_v, s3_v, s4_v;
    reg [35:0] s1_w, s2_w, s3_w, s4_w;
    reg [17:0] s2_ea, s3_ea, s4_ea;

    // Repeat buffer
    reg [1:0]  rs_reg;
    reg [7:0]  rpt_cnt;
    reg        rpt_two;
    reg        rpt_sel;
    reg [35:0] rpt_buf [0:1];

    // ====================
    // Wishbone slave
    wire access = cyc_i & stb_i & ~ack_o;
    wire stall  = we_i & (adr_i == `A_ISSUE) & (rs_reg == RS_RUN);
    wire take   = access & ~stall;
    wire wr     = take & we_i;
    wire [2:0] grp = adr_i[7:5];
    wire [2:0] slot = adr_i[4:2];

    function [31:0] merge;
        input [31:0] o;
        input [31:0] d;
        input [3:0]  s;
        begin
            merge = {s[3] ? d[31:24] : o[31:24], s[2] ? d[23:16] : o[23:16],
                     s[1] ? d[15:8] : o[15:8], s[0] ? d[7:0] : o[7:0]};
        end
    endfunction

    // Unmapped offsets read zero and ignore writes, but are still acked
    reg [31:0] rdata;
    always @* begin
        rdata = 32'h0000_0000;
        if (grp == `A_IDX_TAG) begin
            rdata = {14'h0000, index_reg[slot]};
        end else if (grp == `A_ABR_TAG) begin
            rdata = {8'h00, address_base[slot]};
        end else begin
            case (adr_i)
                `A_ACC_LO:   rdata = acc_reg[31:0];
                `A_ACC_HI:   rdata = {28'h0000000, acc_reg[35:32]};
                `A_QUO_LO:   rdata = quo_reg[31:0];
                `A_QUO_HI:   rdata = {28'h0000000, quo_reg[35:32]};
                `A_EXP:      rdata = {24'h000000, exp_reg};
                `A_TIMER:    rdata = {8'h00, timer_reg};
                `A_IC:       rdata = {14'h0000, ic_reg};
                `A_IND:      rdata = {14'h0000, ind_reg};
                `A_DBR:      rdata = {3'h0, dbr_reg};
                `A_PBR:      rdata = {14'h0000, pbr_reg};
                `A_CTL:      rdata = {27'h0000000, tsrc_reg, 2'h0, mode_reg};
                `A_FAULT:    rdata = {27'h0000000, fault_reg};
                `A_ISSUE_HI: rdata = {28'h0000000, issue_hi_reg};
                `A_FETCH:    rdata = {8'h00, fetch_addr_o};
                `A_OPER:     rdata = {8'h00, oper_addr_o};
                default:     rdata = 32'h0000_0000;
            endcase
        end
    end

    // Byte lanes merged over the addressed register's current value
    wire [31:0] wdata = merge(rdata, dat_i, sel_i);

    // Ack one cycle after the request is taken (an ISSUE write waits out a replay), dropped the cycle after
    always @(posedge clk_i) begin
        if (rst_i) begin
            ack_o <= 1'b0;
            dat_o <= 32'h0000_0000;
        end else begin
            ack_o <= take;
            if (take) begin
                dat_o <= rdata;
            end
        end
    end

    // ====================
    // Issue and repeat control
    wire        iss_fire = wr & (adr_i == `A_ISSUE);
    wire [35:0] iss_word = {issue_hi_reg, dat_i};
    wire        is_rpt   = iss_word[26:18] == `OP_RPT;
    wire        inject   = iss_fire | (rs_reg == RS_RUN);
    wire [35:0] inj_word = (rs_reg == RS_RUN) ? rpt_buf[rpt_sel] : iss_word;
    assign busy_o = rs_reg == RS_RUN;
    assign mode_o = mode_reg;

    // Repeat replays the buffer, not memory, so the counter holds still
    always @(posedge clk_i) begin
        if (rst_i) begin
            rs_reg     <= RS_IDLE;
            rpt_cnt    <= 8'h00;
            rpt_two    <= 1'b0;
            rpt_sel    <= 1'b0;
            rpt_buf[0] <= 36'h0;
            rpt_buf[1] <= 36'h0;
        end else begin
            case (rs_reg)
                RS_IDLE: begin
                    if (iss_fire & is_rpt) begin
                        rpt_cnt <= iss_word[7:0];
                        rpt_two <= iss_word[30];
                        rpt_sel <= 1'b0;
                        rs_reg  <= RS_CAPT;
                    end
                end
                RS_CAPT: begin
                    if (iss_fire) begin
                        rpt_buf[rpt_sel] <= iss_word;
                        if (rpt_two & ~rpt_sel) begin
                            rpt_sel <= 1'b1;
                        end else begin
                            rpt_sel <= 1'b0;
                            rs_reg  <= (rpt_cnt == 8'h00) ? RS_IDLE : RS_RUN;
                        end
                    end
                end
                RS_RUN: begin
                    if (rpt_two & ~rpt_sel) begin
                        rpt_sel <= 1'b1;
                    end else begin
                        rpt_sel <= 1'b0;
                        rpt_cnt <= rpt_cnt - 8'h01;
                        if (rpt_cnt == 8'h01) begin
                            rs_reg <= RS_IDLE;
                        end
                    end
                end
                default: rs_reg <= RS_IDLE;
            endcase
        end
    end

    // ====================
    // Address preparation
    wire [5:0]  s1_mod = s1_w[35:30];
    reg  [17:0] mod_val;
    // Halves of the accumulator and quotient act as index values
    always @* begin
        mod_val = 18'h00000;
        if (s1_mod[5:4] == 2'b00) begin
            case (s1_mod[3:0])
                4'h1:    mod_val = acc_reg[35:18];
                4'h2:    mod_val = quo_reg[35:18];
                4'h4:    mod_val = ic_reg;
                4'h5:    mod_val = acc_reg[17:0];
                4'h6:    mod_val = quo_reg[17:0];
                4'h8, 4'h9, 4'hA, 4'hB, 4'hC, 4'hD, 4'hE, 4'hF:
                         mod_val = index_reg[s1_mod[2:0]];
                default: mod_val = 18'h00000;
            endcase
        end
    end
    // Only register modification adds here; other classes pass the field on
    wire [17:0] ea_next = s1_w[17:0] + mod_val;

    // Operand translation, absolute bypasses unless base bit is set
    wire        abs_mode = mode_reg == `MODE_ABS;
    wire [23:0] base_rel = address_base[s3_ea[17:15]] + {9'h000, s3_ea[14:0]};
    wire [23:0] proc_rel = {pbr_reg, 6'h00} + {6'h00, s3_ea};
    wire [23:0] oper_next = s3_w[`I_BASE] ? base_rel :
                            (abs_mode ? {6'h00, s3_ea} : proc_rel);
    wire [23:0] fetch_next = abs_mode ? {6'h00, ic_reg} :
                             {pbr_reg, 6'h00} + {6'h00, ic_reg};

    // ====================
    // Protection check
    wire [8:0] s3_op  = s3_w[26:18];
    wire priv_op  = s3_op[8:4] == `OP_PRIV_TAG;
    wire unas_op  = s3_op >= `OP_LIMIT;
    wire slave    = mode_reg == `MODE_SLV;
    wire f_priv   = s3_v & priv_op & slave;
    wire f_unas   = s3_v & unas_op & slave;
    // Faulted words never reach execute, so no state changes
    wire pass     = s3_v & ~f_priv & ~f_unas;

    // Four words in flight, one per stage
    always @(posedge clk_i) begin
        if (rst_i) begin
            s1_v <= 1'b0;
            s2_v <= 1'b0;
            s3_v <= 1'b0;
            s4_v <= 1'b0;
            s1_w <= 36'h0;
            s2_w <= 36'h0;
            s3_w <= 36'h0;
            s4_w <= 36'h0;
            s2_ea <= 18'h00000;
            s3_ea <= 18'h00000;
            s4_ea <= 18'h00000;
            oper_addr_o <= 24'h000000;
            fetch_addr_o <= 24'h000000;
            intr_take_o <= 1'b0;
        end else begin
            s1_v <= inject;
            s1_w <= inj_word;
            s2_v <= s1_v;
            s2_w <= s1_w;
            s2_ea <= ea_next;
            s3_v <= s2_v;
            s3_w <= s2_w;
            s3_ea <= s2_ea;
            s4_v <= pass;
            s4_w <= s3_w;
            s4_ea <= s3_ea;
            if (s3_v) begin
                oper_addr_o <= oper_next;
            end
            if (iss_fire) begin
                fetch_addr_o <= fetch_next;
            end
            intr_take_o <= intr_req_i & s4_v & ~s4_w[`I_INH];
        end
    end

    // ====================
    // Execute
    wire [8:0]  op   = s4_w[26:18];
    wire [36:0] sum  = {1'b0, acc_reg} + {19'h00000, s4_ea};
    wire [36:0] diff = {1'b0, acc_reg} - {19'h00000, s4_ea};
    wire [71:0] aq_sh = {acc_reg, quo_reg} << s4_ea[6:0];
    wire [8:0]  esum = {exp_reg[7], exp_reg} + {s4_ea[7], s4_ea[7:0]};
    wire        add_ovf = ~acc_reg[35] & sum[35];
    wire        omask = ind_reg[`IND_OMASK];
    wire        pmask = ind_reg[`IND_PMASK];
    wire        ex    = s4_v;
    wire        x_ada = ex & (op == `OP_ADA);
    wire        x_fade = ex & (op == `OP_FADE);
    wire        ovf_hit = x_ada & add_ovf & ~omask;
    wire        par_hit = parity_err_i & ~pmask;

    // Timer source: prescaled tick or memory access strobe
    wire tick = tick_reg == TICK_LAST;
    wire dec  = tsrc_reg ? mem_access_i : tick;
    wire t_run = dec & (timer_reg == 24'h000001);
    wire f_tmr = t_run & slave;

    // Hardware sets beat a software clear in the same cycle
    wire [4:0] f_set = {par_hit, ovf_hit, f_tmr, f_unas, f_priv};

    always @(posedge clk_i) begin
        if (rst_i) begin
            tick_reg <= 12'h000;
            fault_o <= 1'b0;
        end else begin
            tick_reg <= tick ? 12'h000 : tick_reg + 12'h001;
            fault_o <= |f_set;
        end
    end

    // Register file, bus writes first and execute results layered on top
    always @(posedge clk_i) begin
        if (rst_i) begin
            acc_reg <= 36'h0;
            quo_reg <= 36'h0;
            exp_reg <= 8'h00;
            timer_reg <= 24'h000000;
            ic_reg <= 18'h00000;
            ind_reg <= 18'h00000;
            dbr_reg <= 29'h0;
            pbr_reg <= 18'h00000;
            mode_reg <= `MODE_ABS;
            tsrc_reg <= 1'b0;
            fault_reg <= 5'h00;
            issue_hi_reg <= 4'h0;
            for (k = 0; k < 8; k = k + 1) begin
                index_reg[k] <= 18'h00000;
                address_base[k] <= 24'h000000;
            end
        end else begin
            // Countdown stops at zero; loads override counting
            if (dec & (timer_reg != 24'h000000)) begin
                timer_reg <= timer_reg - 24'h000001;
            end
            if (iss_fire) begin
                ic_reg <= ic_reg + 18'h00001;
            end
            if (wr) begin
                if (grp == `A_IDX_TAG) begin
                    index_reg[slot] <= wdata[17:0];
                end else if (grp == `A_ABR_TAG) begin
                    address_base[slot] <= wdata[23:0];
                end
                case (adr_i)
                    `A_ACC_LO:   acc_reg[31:0] <= merge(acc_reg[31:0], dat_i, sel_i);
                    `A_ACC_HI:   acc_reg[35:32] <= sel_i[0] ? dat_i[3:0] : acc_reg[35:32];
                    `A_QUO_LO:   quo_reg[31:0] <= merge(quo_reg[31:0], dat_i, sel_i);
                    `A_QUO_HI:   quo_reg[35:32] <= sel_i[0] ? dat_i[3:0] : quo_reg[35:32];
                    `A_EXP:      exp_reg <= sel_i[0] ? dat_i[7:0] : exp_reg;
                    `A_TIMER:    timer_reg <= wdata[23:0];
                    `A_IC:       ic_reg <= wdata[17:0];
                    `A_IND:      ind_reg <= wdata[17:0];
                    `A_DBR:      dbr_reg <= wdata[28:0];
                    `A_PBR:      pbr_reg <= wdata[17:0];
                    `A_ISSUE_HI: issue_hi_reg <= sel_i[0] ? dat_i[3:0] : issue_hi_reg;
                    `A_CTL: begin
                        if (sel_i[0]) begin
                            mode_reg <= dat_i[1:0];
                            tsrc_reg <= dat_i[`CTL_TSRC];
                        end
                    end
                    default: ;
                endcase
            end
            // Sticky faults clear by writing ones, a new event still lands
            fault_reg <= ((wr & (adr_i == `A_FAULT) & sel_i[0]) ?
                          (fault_reg & ~dat_i[4:0]) : fault_reg) | f_set;
            // Absolute indicator mirrors the mode
            ind_reg[`IND_ABS] <= abs_mode;
            if (par_hit) begin
                ind_reg[`IND_PAR] <= 1'b1;
            end
            if (ex) begin
                case (op)
                    `OP_LDA: begin
                        acc_reg <= {18'h00000, s4_ea};
                        ind_reg[`IND_ZERO] <= s4_ea == 18'h00000;
                        ind_reg[`IND_NEG] <= 1'b0;
                    end
                    `OP_LDQ: begin
                        quo_reg <= {18'h00000, s4_ea};
                        ind_reg[`IND_ZERO] <= s4_ea == 18'h00000;
                        ind_reg[`IND_NEG] <= 1'b0;
                    end
                    `OP_ADA: begin
                        acc_reg <= sum[35:0];
                        ind_reg[`IND_ZERO] <= sum[35:0] == 36'h0;
                        ind_reg[`IND_NEG] <= sum[35];
                        ind_reg[`IND_CARRY] <= sum[36];
                        if (ovf_hit) begin
                            ind_reg[`IND_OVF] <= 1'b1;
                        end
                    end
                    `OP_CMPA: begin
                        // Outcome kept for later conditional transfers
                        ind_reg[`IND_ZERO] <= diff[35:0] == 36'h0;
                        ind_reg[`IND_NEG] <= diff[35];
                        ind_reg[`IND_CARRY] <= ~diff[36];
                    end
                    `OP_LDE: exp_reg <= s4_ea[7:0];
                    `OP_FADE: begin
                        // Mantissa stays in the accumulator
                        exp_reg <= esum[7:0];
                        ind_reg[`IND_ZERO] <= acc_reg == 36'h0;
                        if (esum[8] != esum[7]) begin
                            ind_reg[`IND_EOVF] <= ~esum[8];
                            ind_reg[`IND_EUNF] <= esum[8];
                        end
                    end
                    `OP_LLS: begin
                        acc_reg <= aq_sh[71:36];
                        quo_reg <= aq_sh[35:0];
                        ind_reg[`IND_ZERO] <= aq_sh == 72'h0;
                        ind_reg[`IND_NEG] <= aq_sh[71];
                    end
                    `OP_LDBR: dbr_reg <= {acc_reg[10:0], s4_ea};
                    `OP_LDT: timer_reg <= acc_reg[23:0];
                    default: begin
                        if (op[8:3] == `OP_LDX_TAG) begin
                            index_reg[op[2:0]] <= s4_ea;
                            ind_reg[`IND_ZERO] <= s4_ea == 18'h00000;
                        end
                    end
                endcase
            end
        end
    end
endmodule

// ---- testbench/sysctl_model.sv ----
// Behavioural system controller: access strobes, parity events, interrupt level
`timescale 1ns/1ps
module sysctl_model (
    input  wire logic clk_i,
    input  wire logic mem_go_i,
    input  wire logic par_go_i,
    input  wire logic irq_i,
    output logic      mem_access_o,
    output logic      parity_err_o,
    output logic      intr_req_o
);
    // ==========================================
    // Strobes
    // Access strobe every other cycle, like a slow store; quiet from the first edge in reset
    always @(posedge clk_i) begin
        mem_access_o <= mem_go_i && !mem_access_o;
        parity_err_o <= par_go_i;
        intr_req_o   <= irq_i;
    end
endmodule

// ---- testbench/core_monitor.sv ----
// Port checker for the mode and decode core
`timescale 1ns/1ps
module core_monitor (
    input wire logic        clk_i,
    input wire logic        rst_i,
    input wire logic [7:0]  adr_i,
    input wire logic        we_i,
    input wire logic        cyc_i,
    input wire logic        stb_i,
    input wire logic        ack_o,
    input wire logic [31:0] dat_o,
    input wire logic        intr_req_i,
    input wire logic        intr_take_o,
    input wire logic [1:0]  mode_o,
    input wire logic        busy_o,
    input wire logic        fault_o
);
    // ==========================================
    // Properties
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);
    property p_rst; disable iff (1'b0) rst_i |=> !ack_o && !busy_o && mode_o == 2'h0; endproperty
    property p_ack1; ack_o |=> !ack_o; endproperty
    property p_ack_src; $rose(ack_o) |-> $past(cyc_i && stb_i); endproperty
    property p_ack_gap; cyc_i && stb_i && !ack_o && !busy_o |=> ack_o; endproperty
    property p_zero_rd; ack_o && !we_i && (adr_i[7:2] == 6'h0C || adr_i[7]) |-> dat_o == 32'h0;
    endproperty
    property p_acc_hi; ack_o && !we_i && adr_i[7:2] inside {6'h01, 6'h03} |-> dat_o[31:4] == 28'h0;
    endproperty
    property p_ind_abs; ack_o && !we_i && adr_i[7:2] == 6'h07 |-> dat_o[10] == (mode_o == 2'h0);
    endproperty
    property p_stall; busy_o && cyc_i && stb_i && we_i && adr_i[7:2] == 6'h0C && !ack_o |=> !ack_o;
    endproperty
    property p_intr; intr_take_o |-> $past(intr_req_i); endproperty
    a_rst: assert property (p_rst) else $error("state not cleared by reset");
    a_ack1: assert property (p_ack1) else $error("ack longer than one cycle");
    a_ack_src: assert property (p_ack_src) else $error("ack without request");
    a_ack_gap: assert property (p_ack_gap) else $error("ack late");
    a_zero_rd: assert property (p_zero_rd) else $error("issue or unmapped read not zero");
    a_acc_hi: assert property (p_acc_hi) else $error("upper word wider than 4 bits");
    a_ind_abs: assert property (p_ind_abs) else $error("absolute bit wrong");
    a_stall: assert property (p_stall) else $error("issue taken during replay");
    a_intr: assert property (p_intr) else $error("interrupt taken unrequested");
    c_fault: cover property (fault_o);
    c_take: cover property (intr_take_o);
    c_busy: cover property (busy_o);
endmodule
bind processor_mode_and_decode_core core_monitor mon (.clk_i(clk_i), .rst_i(rst_i),
    .adr_i(adr_i), .we_i(we_i), .cyc_i(cyc_i), .stb_i(stb_i), .ack_o(ack_o), .dat_o(dat_o),
    .intr_req_i(intr_req_i), .intr_take_o(intr_take_o), .mode_o(mode_o), .busy_o(busy_o),
    .fault_o(fault_o));

// ---- testbench/testbench.sv ----
// Self-checking bench for the mode and decode core
`timescale 1ns/1ps
module testbench;
    logic        clk_i = 0, rst_i = 1, we_i = 0, cyc_i = 0, stb_i = 0;
    logic        mem_go = 0, par_go = 0, irq = 0, base_bit = 0;
    logic [7:0]  adr_i = 8'h00;
    logic [31:0] dat_i = 32'h0, dat_o, rd;
    logic        ack_o, mem_access_i, parity_err_i, intr_req_i, fault_o, intr_take_o, busy_o;
    logic [23:0] fetch_addr_o, oper_addr_o;
    logic [1:0]  mode_o;
    int          errors = 0, cmp_count = 0, faults = 0, takes = 0;
    // ==========================================
    // Clock, core and partner
    always #5 clk_i = ~clk_i;
    processor_mode_and_decode_core #(.TICK_CYCLES(4)) DUT (.clk_i(clk_i), .rst_i(rst_i),
        .adr_i(adr_i), .dat_i(dat_i), .dat_o(dat_o), .we_i(we_i), .sel_i(4'hF), .cyc_i(cyc_i),
        .stb_i(stb_i), .ack_o(ack_o), .mem_access_i(mem_access_i), .parity_err_i(parity_err_i),
        .intr_req_i(intr_req_i), .fault_o(fault_o), .intr_take_o(intr_take_o),
        .fetch_addr_o(fetch_addr_o), .oper_addr_o(oper_addr_o), .mode_o(mode_o), .busy_o(busy_o));
    sysctl_model SC (.clk_i(clk_i), .mem_go_i(mem_go), .par_go_i(par_go), .irq_i(irq),
        .mem_access_o(mem_access_i), .parity_err_o(parity_err_i), .intr_req_o(intr_req_i));
    // Pulse counters, since fault and take pulses last one cycle
    always @(posedge clk_i) begin
        if (fault_o === 1'b1) faults++;
        if (intr_take_o === 1'b1) takes++;
    end
    // ==========================================
    // Bus and compare tasks
    task automatic chk(string n, logic [31:0] e, logic [31:0] g);
        cmp_count++;
        if (g !== e) begin
            errors++;
            $display("ERROR %s expected %h seen %h", n, e, g);
        end
    endtask
    // No limit of its own: an ISSUE write may stall through a replay; watchdog ends a hang
    task automatic wb(logic w, logic [7:0] a, logic [31:0] d);
        @(posedge clk_i);
        cyc_i <= 1;
        stb_i <= 1;
        we_i <= w;
        adr_i <= a;
        dat_i <= d;
        do
            @(posedge clk_i);
        while (ack_o !== 1'b1);
        rd = dat_o;
        cyc_i <= 0;
        stb_i <= 0;
        we_i <= 0;
    endtask
    task automatic rc(string n, logic [7:0] a, logic [31:0] e);
        wb(0, a, 32'h0);
        chk(n, e, rd);
    endtask
    // Upper nibble first, low word launches; then pipeline drains
    task automatic issue(logic [8:0] op, logic [17:0] ad, logic [5:0] md, logic inh);
        logic [35:0] w;
        w = {md, base_bit, inh, 1'b0, op, ad};
        wb(1, 8'h34, {28'h0, w[35:32]});
        wb(1, 8'h30, w[31:0]);
        repeat (6) @(posedge clk_i);
    endtask
    // ==========================================
    // Scenarios
    task automatic t_regs;
        wb(1, 8'h04, 32'hFFFFFFFF);
        rc("acc_hi", 8'h04, 32'h0000000F);
        wb(1, 8'h10, 32'h000001AB);
        rc("exponent", 8'h10, 32'h000000AB);
        wb(1, 8'h5C, 32'h000FFFFF);
        rc("index7", 8'h5C, 32'h0003FFFF);
        wb(1, 8'h80, 32'h00000005);
        rc("unmapped", 8'h80, 32'h0);
        rc("ind_abs", 8'h1C, 32'h00000400);
    endtask
    task automatic t_exec;
        issue(9'h000, 18'h12345, 6'h00, 0);
        rc("lda", 8'h00, 32'h00012345);
        chk("oper_abs", 32'h00012345, {8'h00, oper_addr_o});
        issue(9'h002, 18'h00001, 6'h05, 0);
        rc("ada_lower", 8'h00, 32'h0002468B);
        issue(9'h003, 18'h2468B, 6'h00, 0);
        rc("cmp_ind", 8'h1C, 32'h00000405);
        rc("fetch_abs", 8'h38, 32'h00000002);
        wb(1, 8'h0C, 32'h00000008);
        issue(9'h006, 18'h00001, 6'h00, 0);
        rc("lls_acc", 8'h00, 32'h00048D17);
        rc("lls_quo", 8'h0C, 32'h0);
        issue(9'h180, 18'h00001, 6'h00, 0);
        rc("dbr_abs", 8'h20, 32'h145C0001);
    endtask
    task automatic t_modes;
        wb(1, 8'h28, 32'h00000001);
        wb(1, 8'h24, 32'h00000010);
        wb(1, 8'h18, 32'h00000020);
        issue(9'h001, 18'h00007, 6'h00, 0);
        rc("fetch_master", 8'h38, 32'h00000420);
        chk("fetch_port", 32'h00000420, {8'h00, fetch_addr_o});
        chk("oper_master", 32'h00000407, {8'h00, oper_addr_o});
        wb(1, 8'h64, 32'h00001000);
        base_bit = 1;
        issue(9'h001, 18'h08005, 6'h00, 0);
        base_bit = 0;
        chk("oper_base", 32'h00001005, {8'h00, oper_addr_o});
        wb(1, 8'h28, 32'h00000002);
        issue(9'h180, 18'h00777, 6'h00, 0);
        issue(9'h1FF, 18'h00000, 6'h00, 0);
        rc("fault_bits", 8'h2C, 32'h00000003);
        rc("dbr_kept", 8'h20, 32'h145C0001);
        chk("fault_pulses", 32'd2, faults);
    endtask
    // Memory source: prescaled ticks must not count, access strobes must
    task automatic t_timer;
        wb(1, 8'h2C, 32'h0000001F);
        wb(1, 8'h28, 32'h00000012);
        wb(1, 8'h14, 32'h00000003);
        repeat (20) @(posedge clk_i);
        rc("timer_idle", 8'h14, 32'h00000003);
        mem_go <= 1;
        repeat (20) @(posedge clk_i);
        mem_go <= 0;
        rc("timer_zero", 8'h14, 32'h0);
        rc("fault_timer", 8'h2C, 32'h00000004);
    endtask
    task automatic t_repeat;
        wb(1, 8'h28, 32'h0);
        wb(1, 8'h00, 32'h0);
        issue(9'h190, 18'h00008, 6'h00, 0);
        issue(9'h002, 18'h00001, 6'h00, 0);
        issue(9'h001, 18'h00005, 6'h00, 0);
        rc("replay_acc", 8'h00, 32'h00000009);
        rc("after_quo", 8'h08, 32'h00000005);
    endtask
    task automatic t_irq_par;
        irq <= 1;
        issue(9'h001, 18'h00001, 6'h00, 1);
        chk("take_inhibited", 32'd0, takes);
        issue(9'h001, 18'h00002, 6'h00, 0);
        irq <= 0;
        chk("take", 32'd1, takes);
        wb(1, 8'h2C, 32'h0000001F);
        wb(1, 8'h1C, 32'h00000200);
        par_go <= 1;
        @(posedge clk_i);
        par_go <= 0;
        rc("par_masked", 8'h2C, 32'h0);
        wb(1, 8'h1C, 32'h0);
        par_go <= 1;
        @(posedge clk_i);
        par_go <= 0;
        rc("par_open", 8'h2C, 32'h00000010);
    endtask
    // ==========================================
    // Verdict
    task automatic summarize;
        $display("Comparisons %0d, mismatches %0d", cmp_count, errors);
        if (errors == 0 && cmp_count > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask
    // Watchdog far beyond the few hundred cycles the run needs
    initial begin
        #300000;
        errors++;
        summarize();
    end
    initial begin
        repeat (2) @(posedge clk_i);
        rst_i <= 0;
        t_regs();
        t_exec();
        t_modes();
        t_timer();
        t_repeat();
        t_irq_par();
        summarize();
    end
endmodule
